/* File: eps_pkg.sv */
// Package with register map, field layout and timing constants for the PWM block
// Summary of operation
// [R1] Selector codes pick timer pairs 1/2, 3/4, 5/6
// [R2] Select reg A: ch3 7-6, ch2 4-3, ch1 1-0
// [R3] Select reg B: ch5 3-2, ch4 1-0
// [R4] Auto restart: status clears when fault ends
// [R5] Manual restart: status held until software clears
// [R6] Source 000 off, 001/010/011 comparator triggers
// [R7] Source 1xx adds low fault pin trigger
// [R8] A/C shutdown level: 0, 1 or tri-state
// [R9] B/D shutdown level from bits 1-0
// [R10] Sync enable gates comparator trigger by timer1
// [R11] Restart enable bit picks auto or software restart
// [R12] Delay count holds off active edge per cycle
// [R13] Steering change at period start or next cycle
// [R14] Steering bits route PWM with polarity to pins
// [R15] Steering only in PWM single-output configuration
// [R16] Steering bits 7-5 read zero, ignore writes
// [R17] Mode low bits set active-low for A/C, B/D
// [R18] Output config: single, forward, half, reverse
// [R19] Resume driving at next PWM period start
package eps_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_TSEL_A = 8'h00;
    localparam logic [7:0] ADDR_TSEL_B = 8'h04;
    localparam logic [7:0] ADDR_SHDN   = 8'h08;
    localparam logic [7:0] ADDR_RSTDLY = 8'h0c;
    localparam logic [7:0] ADDR_STEER  = 8'h10;
    localparam logic [7:0] ADDR_MODE   = 8'h14;
    localparam logic [7:0] ADDR_IRQST  = 8'h18;
    localparam logic [7:0] ADDR_IRQMSK = 8'h1c;
    // Writable masks and reset values
    localparam logic [7:0] MASK_TSEL_A = 8'hdb;
    localparam logic [7:0] MASK_TSEL_B = 8'h0f;
    localparam logic [7:0] MASK_STEER  = 8'h1f;
    localparam logic [7:0] RST_STEER   = 8'h01;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    // Field positions
    localparam int SHDN_STAT_BIT = 7;
    localparam int RST_EN_BIT    = 7;
    localparam int STEER_SYNC    = 4;
    // Source select codes
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam logic [2:0] SRC_C1  = 3'h1;
    localparam logic [2:0] SRC_C2  = 3'h2;
    localparam logic [2:0] SRC_C12 = 3'h3;
    // Pin state, mode and output configuration codes
    localparam logic [1:0] PSS_LOW  = 2'h0;
    localparam logic [1:0] PSS_HIGH = 2'h1;
    localparam logic [1:0] PWM_MODE = 2'h3;
    localparam logic [1:0] CFG_SING = 2'h0;
    localparam logic [1:0] CFG_FWD  = 2'h1;
    localparam logic [1:0] CFG_HALF = 2'h2;
    localparam logic [1:0] CFG_REV  = 2'h3;
    // Instruction cycle is four oscillator periods
    localparam int OSC_PER_CYC = 4;
    localparam logic [1:0] CYC_LAST = 2'(OSC_PER_CYC - 1);
    // Interrupt status bits
    localparam int IRQ_SHDN = 0;
    localparam int IRQ_PER  = 1;
    // Auto-shutdown register layout
    typedef struct packed {
        logic       stat;
        logic [2:0] src;
        logic [1:0] pss_ac;
        logic [1:0] pss_bd;
    } eps_shdn_t;
    // Unit mode register layout
    typedef struct packed {
        logic [1:0] cfg;
        logic [1:0] dcb;
        logic [1:0] mode_hi;
        logic [1:0] pol;
    } eps_mode_t;
    // Restart state
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_SHDN = 2'b01,
        ST_WAIT = 2'b10
    } eps_state_t;
endpackage : eps_pkg

/* File: eps_top.sv */
// Enhanced PWM shutdown, delay and steering logic with APB registers
`timescale 1ns/1ns
module eps_top (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic       pwm_raw,        // Core PWM waveform
    input  wire logic       period_start,   // Pulse at PWM period start
    input  wire logic       timer1_tick,    // Timer1 sync strobe
    input  wire logic       comparator1_result,
    input  wire logic       comparator2_result,
    input  wire logic       comparator1_sync_en,
    input  wire logic       comparator2_sync_en,
    input  wire logic       fault_input,    // Low level is a fault
    input  wire logic [3:0] port_out,       // Port latch values
    input  wire logic [3:0] port_oe,        // Port output enables
    output logic      [3:0] pin_out,        // Pin order d,c,b,a
    output logic      [3:0] pin_oe,
    output logic      [9:0] timebase_sel,   // ch5..ch1 selectors
    output logic            irq
);
    // Register storage
    logic [7:0]           tsel_a_ff;
    logic [7:0]           tsel_b_ff;
    eps_pkg::eps_shdn_t   shdn_ff;
    logic [7:0]           rstdly_ff;
    logic [7:0]           steer_ff;
    logic [3:0]           steer_act_ff;
    eps_pkg::eps_mode_t   mode_ff;
    logic [1:0]           irq_st_ff;
    logic [1:0]           irq_msk_ff;
    eps_pkg::eps_state_t  st_ff;
    logic [1:0]           cyc_ff;        // Instruction cycle divider
    logic                 c1s_ff;        // Timer1-synced comparators
    logic                 c2s_ff;
    logic [6:0]           dly_ff;        // Active-edge delay counter
    logic                 pwm_d_ff;      // Delayed waveform
    logic                 pwm_q_ff;      // Previous raw sample
    logic [31:0]          prdata_ff;
    logic                 pready_ff;
    logic [3:0]           pin_out_ff;
    logic [3:0]           pin_oe_ff;
    logic                 irq_ff;

    // Bus decode
    wire       acc    = psel && penable && pready_ff;
    wire       wr     = acc && pwrite;
    // Read data is captured one edge before pready is seen high
    wire       rd     = psel && penable && !pready_ff && !pwrite;
    wire [7:0] wd     = pwdata[7:0];
    wire       cyc_en = (cyc_ff == eps_pkg::CYC_LAST);
    wire       wr_shdn = wr && (paddr == eps_pkg::ADDR_SHDN);
    wire       wr_steer = wr && (paddr == eps_pkg::ADDR_STEER);

    // [R10] Comparator source selection
    wire c1_eff = comparator1_sync_en ? c1s_ff : comparator1_result;
    wire c2_eff = comparator2_sync_en ? c2s_ff : comparator2_result;
    // [R6] Comparator triggers
    wire [2:0] src = shdn_ff.src;
    wire cmp_trig = (src[1:0] == eps_pkg::SRC_C1[1:0] && c1_eff) ||
                    (src[1:0] == eps_pkg::SRC_C2[1:0] && c2_eff) ||
                    (src[1:0] == eps_pkg::SRC_C12[1:0] &&
                     (c1_eff || c2_eff));
    // [R7] Fault pin trigger
    wire fault  = (src != eps_pkg::SRC_OFF) &&
                  (cmp_trig || (src[2] && !fault_input));
    wire auto_rs = rstdly_ff[eps_pkg::RST_EN_BIT];

    // Software clear of the status bit (manual restart only)
    wire sw_clr = wr_shdn && !wd[eps_pkg::SHDN_STAT_BIT];

    // [R4] [R5] Status bit next value, set wins over clear
    wire nxt_stat = fault || (!auto_rs && !sw_clr && shdn_ff.stat);

    // [R15] Steering active only in PWM single output
    wire is_pwm   = (mode_ff.mode_hi == eps_pkg::PWM_MODE);
    wire steer_ok = is_pwm && (mode_ff.cfg == eps_pkg::CFG_SING);

    // [R17] Polarity per pin pair
    wire w_ac = pwm_d_ff ^ mode_ff.pol[1];
    wire w_bd = pwm_d_ff ^ mode_ff.pol[0];
    wire i_ac = mode_ff.pol[1];
    wire i_bd = mode_ff.pol[0];

    // [R18] Waveform per output configuration
    logic [3:0] drv_val;
    logic [3:0] drv_en;
    always_comb begin
        drv_val = port_out;
        drv_en  = port_oe;
        if (is_pwm) begin
            case (mode_ff.cfg)
                // [R14] Steered single output
                eps_pkg::CFG_SING: begin
                    drv_val = {steer_act_ff[3] ? w_bd : port_out[3],
                               steer_act_ff[2] ? w_ac : port_out[2],
                               steer_act_ff[1] ? w_bd : port_out[1],
                               steer_act_ff[0] ? w_ac : port_out[0]};
                    drv_en  = steer_act_ff | port_oe;
                end
                // D modulated, A active
                eps_pkg::CFG_FWD: begin
                    drv_val = {w_bd, i_ac, i_bd, !i_ac};
                    drv_en  = 4'hf;
                end
                // A and B complementary
                eps_pkg::CFG_HALF: begin
                    drv_val = {port_out[3:2], !w_bd, w_ac};
                    drv_en  = {port_oe[3:2], 2'h3};
                end
                // B modulated, C active
                eps_pkg::CFG_REV: begin
                    drv_val = {i_bd, !i_ac, w_bd, i_ac};
                    drv_en  = 4'hf;
                end
                default: drv_en = port_oe;
            endcase
        end
    end

    // [R8] [R9] Shutdown pin levels
    wire [1:0] ac = shdn_ff.pss_ac;
    wire [1:0] bd = shdn_ff.pss_bd;
    wire [3:0] sd_val = {bd[0], ac[0], bd[0], ac[0]};
    wire [3:0] sd_en  = {!bd[1], !ac[1], !bd[1], !ac[1]};
    wire       held   = (st_ff != eps_pkg::ST_RUN) && is_pwm;

    // Read mux
    wire [7:0] rsel =
        (paddr == eps_pkg::ADDR_TSEL_A)  ? tsel_a_ff :
        (paddr == eps_pkg::ADDR_TSEL_B)  ? tsel_b_ff :
        (paddr == eps_pkg::ADDR_SHDN)    ? shdn_ff :
        (paddr == eps_pkg::ADDR_RSTDLY)  ? rstdly_ff :
        (paddr == eps_pkg::ADDR_STEER)   ? steer_ff :
        (paddr == eps_pkg::ADDR_MODE)    ? mode_ff :
        (paddr == eps_pkg::ADDR_IRQST)   ? {6'h00, irq_st_ff} :
        (paddr == eps_pkg::ADDR_IRQMSK)  ? {6'h00, irq_msk_ff} : 8'h00;

    // Interrupt events; a read clears what it captured
    wire [1:0] ev = {period_start, fault && !shdn_ff.stat};
    wire [1:0] nxt_irq_st = ev |
        ((rd && paddr == eps_pkg::ADDR_IRQST) ? 2'h0 : irq_st_ff);

    // Bus answer: one wait state per access
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            prdata_ff <= rd ? {24'h0, rsel} : 32'h0;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tsel_a_ff  <= eps_pkg::RST_ZERO;
            tsel_b_ff  <= eps_pkg::RST_ZERO;
            rstdly_ff  <= eps_pkg::RST_ZERO;
            steer_ff   <= eps_pkg::RST_STEER;
            mode_ff    <= eps_pkg::RST_ZERO;
            irq_msk_ff <= 2'h0;
        end else if (wr) begin
            // [R2] Unused bits of select A stay zero
            if (paddr == eps_pkg::ADDR_TSEL_A)
                tsel_a_ff <= wd & eps_pkg::MASK_TSEL_A;
            // [R3] Upper nibble of select B stays zero
            if (paddr == eps_pkg::ADDR_TSEL_B)
                tsel_b_ff <= wd & eps_pkg::MASK_TSEL_B;
            // [R11] Restart enable and delay count
            if (paddr == eps_pkg::ADDR_RSTDLY)
                rstdly_ff <= wd;
            // [R16] Steering upper bits ignore writes
            if (wr_steer)
                steer_ff <= wd & eps_pkg::MASK_STEER;
            if (paddr == eps_pkg::ADDR_MODE)
                mode_ff <= wd;
            if (paddr == eps_pkg::ADDR_IRQMSK)
                irq_msk_ff <= wd[1:0];
        end
    end

    // Shutdown register and interrupt status
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shdn_ff   <= eps_pkg::RST_ZERO;
            irq_st_ff <= 2'h0;
            irq_ff    <= 1'b0;
        end else begin
            shdn_ff.stat <= nxt_stat;
            if (wr_shdn)
                {shdn_ff.src, shdn_ff.pss_ac, shdn_ff.pss_bd} <= wd[6:0];
            irq_st_ff <= nxt_irq_st;
            irq_ff    <= |(nxt_irq_st & irq_msk_ff);
        end
    end

    // [R19] Restart waits for the next period start
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= eps_pkg::ST_RUN;
        end else begin
            case (st_ff)
                eps_pkg::ST_RUN:
                    if (nxt_stat) st_ff <= eps_pkg::ST_SHDN;
                eps_pkg::ST_SHDN:
                    if (!nxt_stat) st_ff <= eps_pkg::ST_WAIT;
                eps_pkg::ST_WAIT:
                    if (nxt_stat) st_ff <= eps_pkg::ST_SHDN;
                    else if (period_start) st_ff <= eps_pkg::ST_RUN;
                default: st_ff <= eps_pkg::ST_RUN;
            endcase
        end
    end

    // Instruction cycle divider and timer1 comparator sync
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_ff <= 2'h0;
            c1s_ff <= 1'b0;
            c2s_ff <= 1'b0;
        end else begin
            cyc_ff <= cyc_ff + 2'h1;
            // [R10] Resample comparators on timer1 strobe
            if (timer1_tick) begin
                c1s_ff <= comparator1_result;
                c2s_ff <= comparator2_result;
            end
        end
    end

    // [R12] Delay the rising edge by the count in cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dly_ff   <= 7'h0;
            pwm_d_ff <= 1'b0;
            pwm_q_ff <= 1'b0;
        end else begin
            pwm_q_ff <= pwm_raw;
            if (!pwm_raw) begin
                pwm_d_ff <= 1'b0;
                dly_ff   <= 7'h0;
            end else if (!pwm_q_ff) begin
                dly_ff   <= rstdly_ff[6:0];
                pwm_d_ff <= (rstdly_ff[6:0] == 7'h0);
            end else if (dly_ff != 7'h0) begin
                if (cyc_en) dly_ff <= dly_ff - 7'h1;
            end else begin
                pwm_d_ff <= 1'b1;
            end
        end
    end

    // [R13] Steering takes effect at period or cycle boundary
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            steer_act_ff <= eps_pkg::RST_ZERO[3:0];
        end else if (!steer_ok) begin
            steer_act_ff <= 4'h0;
        end else if (steer_ff[eps_pkg::STEER_SYNC] ? period_start
                                                   : cyc_en) begin
            steer_act_ff <= steer_ff[3:0];
        end
    end

    // Registered pins: shutdown levels override waveform
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out_ff <= 4'h0;
            pin_oe_ff  <= 4'h0;
        end else begin
            pin_out_ff <= held ? sd_val : drv_val;
            pin_oe_ff  <= held ? sd_en : drv_en;
        end
    end

    // [R1] Selector codes exported to the timer muxes
    assign timebase_sel = {tsel_b_ff[3:0], tsel_a_ff[7:6],
                           tsel_a_ff[4:3], tsel_a_ff[1:0]};
    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = 1'b0 ;
    assign pin_out = pin_out_ff;
    assign pin_oe  = pin_oe_ff;
    assign irq     = irq_ff;

    // Fault with status clear: set must win
    property p_set_wins;
        @(posedge clk) disable iff (sys_rst)
        fault |=> shdn_ff.stat;
    endproperty
    a_set_wins: assert property (p_set_wins) // [R4]
        else $error("fault did not set status");
    // Manual restart holds status
    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        (shdn_ff.stat && !auto_rs && !sw_clr) |=> shdn_ff.stat;
    endproperty
    a_hold: assert property (p_hold) // [R5]
        else $error("status dropped without software");
    // Auto restart clears status
    property p_auto;
        @(posedge clk) disable iff (sys_rst)
        (shdn_ff.stat && auto_rs && !fault) |=> !shdn_ff.stat;
    endproperty
    a_auto: assert property (p_auto) // [R11]
        else $error("auto restart did not clear");
    // Shutdown drives programmed A level
    property p_sd_a;
        @(posedge clk) disable iff (sys_rst)
        held |=> (pin_oe_ff[0] == !$past(ac[1])) &&
                 (!pin_oe_ff[0] || pin_out_ff[0] == $past(ac[0]));
    endproperty
    a_sd_a: assert property (p_sd_a) // [R8]
        else $error("bad A shutdown level");
    // Shutdown drives programmed B enable
    property p_sd_b;
        @(posedge clk) disable iff (sys_rst)
        held |=> pin_oe_ff[1] == !$past(bd[1]);
    endproperty
    a_sd_b: assert property (p_sd_b) // [R9]
        else $error("bad B shutdown enable");
    // Source off never triggers
    property p_off;
        @(posedge clk) disable iff (sys_rst)
        (src == eps_pkg::SRC_OFF) |-> !fault;
    endproperty
    a_off: assert property (p_off) // [R6]
        else $error("shutdown with source off");
    // Fault pin low triggers for source 1xx
    property p_flt;
        @(posedge clk) disable iff (sys_rst)
        (src[2] && !fault_input) |-> fault;
    endproperty
    a_flt: assert property (p_flt) // [R7]
        else $error("fault pin ignored");
    // Steering upper bits stay zero
    property p_steer;
        @(posedge clk) disable iff (sys_rst)
        wr_steer |=> steer_ff[7:5] == 3'h0;
    endproperty
    a_steer: assert property (p_steer) // [R16]
        else $error("steering upper bits set");
    // Outside steerable mode nothing is steered
    property p_steer_ok;
        @(posedge clk) disable iff (sys_rst)
        !steer_ok |=> steer_act_ff == 4'h0;
    endproperty
    a_steer_ok: assert property (p_steer_ok) // [R15]
        else $error("steering outside single PWM");
    // Resume only at period start
    property p_resume;
        @(posedge clk) disable iff (sys_rst)
        (st_ff == eps_pkg::ST_WAIT && !period_start) |=>
            st_ff != eps_pkg::ST_RUN;
    endproperty
    a_resume: assert property (p_resume) // [R19]
        else $error("resumed mid period");
endmodule : eps_top

/* File: eps_bridge_model.sv */
// Far-side model: fault and comparator sources, bridge pin loads
`timescale 1ns/1ns
module eps_bridge_model (
    input  wire logic       clk,
    input  wire logic       fault_req,          // Ask for a pin fault
    input  wire logic       cmp1_req,           // Ask for comparator 1 trip
    input  wire logic       cmp2_req,           // Ask for comparator 2 trip
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic            fault_input,
    output logic            comparator1_result,
    output logic            comparator2_result,
    output logic      [3:0] pin_level           // Resolved pin wires
);
    logic [3:0] last_ff = 4'h0;                 // Last seen pin levels
    assign fault_input = ~fault_req;
    assign comparator1_result = cmp1_req;
    assign comparator2_result = cmp2_req;
    // Record the previous wire level; undriven pins take its inverse
    always @(posedge clk) begin
        last_ff <= pin_level;
    end
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~last_ff);
endmodule : eps_bridge_model

/* File: tb_top.sv */
// Self-checking bench for the PWM shutdown and steering block
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic        clk = 0, sys_rst = 1;         // Clock and reset
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic        pready, pslverr, irq;
    logic        pwm_raw = 0, period_start = 0, timer1_tick = 0;
    logic        fault_req = 0, cmp1_req = 0, cmp2_req = 0;
    logic        fault_input, comparator1_result, comparator2_result;
    logic [3:0]  port_out = 0, port_oe = 0, pin_out, pin_oe, pin_level;
    logic [9:0]  timebase_sel;
    logic [3:0]  per_cnt = 0;                   // PWM period counter
    logic        per_en = 0, cmp_sync = 0;      // Strobe gate, comparator sync
    logic        exp_t;                         // Expected trip
    int          mismatches = 0, n_checks = 0;
    always #20 clk = ~clk;
    // Core period strobe every 16 cycles, timer1 every 8
    always @(posedge clk) begin
        if (per_en) per_cnt <= per_cnt + 4'h1;
        period_start <= per_en && (per_cnt == 4'hf);
        timer1_tick <= per_en && (per_cnt[2:0] == 3'h7);
    end
    eps_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_raw(pwm_raw), .period_start(period_start),
        .timer1_tick(timer1_tick), .comparator1_result(comparator1_result),
        .comparator2_result(comparator2_result),
        .comparator1_sync_en(cmp_sync), .comparator2_sync_en(cmp_sync),
        .fault_input(fault_input), .port_out(port_out), .port_oe(port_oe),
        .pin_out(pin_out), .pin_oe(pin_oe), .timebase_sel(timebase_sel),
        .irq(irq));
    eps_bridge_model u_far (.clk(clk), .fault_req(fault_req),
        .cmp1_req(cmp1_req), .cmp2_req(cmp2_req), .pin_out(pin_out),
        .pin_oe(pin_oe), .fault_input(fault_input),
        .comparator1_result(comparator1_result),
        .comparator2_result(comparator2_result), .pin_level(pin_level));
    // One APB transfer; read data lands in rdat
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge clk);
        penable <= 1;
        // Wait for pready at a rising edge; the watchdog ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        psel <= 0; penable <= 0;
    endtask : apb
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task final_report;
        if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // Watchdog against a hung handshake
    initial begin
        idle(20000);
        mismatches++;
        final_report();
    end
    initial begin
        idle(2);
        sys_rst <= 0;
        // Reset values of all registers
        for (int i = 0; i < 8; i++) begin
            apb(0, 8'(i * 4), 0);
            `CHK(rdat, (i == 4) ? 32'h1 : 32'h0)
        end
        apb(0, 8'h20, 0); `CHK(rdat, 32'h0)
        `CHK(pslverr, 1'b0)
        per_en <= 1;
        apb(1, eps_pkg::ADDR_TSEL_A, 32'hff); apb(0, eps_pkg::ADDR_TSEL_A, 0);
        `CHK(rdat, 32'hdb)
        apb(1, eps_pkg::ADDR_TSEL_B, 32'hff); apb(0, eps_pkg::ADDR_TSEL_B, 0);
        `CHK(rdat, 32'h0f)
        apb(1, eps_pkg::ADDR_STEER, 32'hff); apb(0, eps_pkg::ADDR_STEER, 0);
        `CHK(rdat, 32'h1f)
        for (int c = 0; c < 3; c++) begin
            apb(1, eps_pkg::ADDR_TSEL_A, 32'({2'(c), 1'b0, 2'(c), 1'b0, 2'(c)}));
            apb(1, eps_pkg::ADDR_TSEL_B, 32'({2'(c), 2'(2 - c)}));
            idle(1);
            `CHK(timebase_sel, {2'(c), 2'(2 - c), 2'(c), 2'(c), 2'(c)})
        end
        // Steering of pin A only, others from the port
        port_out <= 4'b1010; port_oe <= 4'b1110; pwm_raw <= 1;
        apb(1, eps_pkg::ADDR_MODE, 32'h0c); apb(1, eps_pkg::ADDR_STEER, 32'h01);
        idle(8);
        `CHK({pin_oe, pin_out}, 8'hfb)
        apb(1, eps_pkg::ADDR_MODE, 32'h0e); idle(6);
        `CHK(pin_out[0], 1'b0)
        apb(1, eps_pkg::ADDR_MODE, 32'h00); idle(6);
        `CHK({pin_oe, pin_out & pin_oe}, 8'hea)
        // Deferred steering change waits for the period start
        port_out <= 4'b1000;
        apb(1, eps_pkg::ADDR_MODE, 32'h0c); apb(1, eps_pkg::ADDR_STEER, 32'h11);
        while (per_cnt != 4'h1) @(posedge clk);
        apb(1, eps_pkg::ADDR_STEER, 32'h13);
        idle(6);
        `CHK(pin_out[1], 1'b0)
        @(posedge period_start); idle(6);
        `CHK(pin_out[1], 1'b1)
        // Every source code against every trigger, auto restart on
        apb(1, eps_pkg::ADDR_STEER, 32'h0f); apb(1, eps_pkg::ADDR_IRQMSK, 32'h1);
        apb(1, eps_pkg::ADDR_RSTDLY, 32'h80);
        for (int c = 0; c < 8; c++) for (int s = 0; s < 3; s++) begin
            apb(1, eps_pkg::ADDR_SHDN, 32'({3'(c), 4'h4}));
            apb(0, eps_pkg::ADDR_IRQST, 0);
            fault_req <= (s == 0); cmp1_req <= (s == 1); cmp2_req <= (s == 2);
            exp_t = (s == 0 && c[2]) || (s == 1 && c[0]) || (s == 2 && c[1]);
            idle(3);
            apb(0, eps_pkg::ADDR_SHDN, 0);
            `CHK(rdat[7], exp_t)
            if (exp_t) `CHK({irq, pin_oe, pin_level}, 9'h1f5)
            fault_req <= 0; cmp1_req <= 0; cmp2_req <= 0;
            idle(3);
            apb(0, eps_pkg::ADDR_SHDN, 0);
            `CHK(rdat[7], 1'b0)
            apb(0, eps_pkg::ADDR_IRQST, 0);
            `CHK(rdat[0], exp_t)
            idle(20);
            `CHK({irq, pin_oe, pin_out}, 9'h0ff)
        end
        // Masked event raises no interrupt; tri-state levels; manual restart
        apb(1, eps_pkg::ADDR_IRQMSK, 32'h0); apb(1, eps_pkg::ADDR_RSTDLY, 32'h0);
        apb(1, eps_pkg::ADDR_SHDN, 32'h49);
        fault_req <= 1; idle(3);
        `CHK({irq, pin_oe, pin_level & pin_oe}, 9'h0aa)
        fault_req <= 0; idle(5);
        apb(0, eps_pkg::ADDR_SHDN, 0);
        `CHK(rdat[7], 1'b1)
        `CHK(pin_oe, 4'b1010)
        apb(1, eps_pkg::ADDR_SHDN, 32'h49); idle(20);
        `CHK(pin_oe, 4'b1111)
        // Rising edge held off by the delay count of 5 cycles
        apb(1, eps_pkg::ADDR_SHDN, 32'h0); apb(1, eps_pkg::ADDR_RSTDLY, 32'h5);
        pwm_raw <= 0; idle(6); pwm_raw <= 1; idle(12);
        `CHK(pin_out[0], 1'b0)
        idle(20);
        `CHK(pin_out[0], 1'b1)
        // Synced comparator trip waits for the timer1 strobe
        apb(1, eps_pkg::ADDR_RSTDLY, 32'h80);
        apb(1, eps_pkg::ADDR_SHDN, 32'h14);
        cmp_sync <= 1;
        while (per_cnt[2:0] != 3'h1) @(posedge clk);
        cmp1_req <= 1;
        apb(0, eps_pkg::ADDR_SHDN, 0);
        `CHK(rdat[7], 1'b0)
        idle(4);
        apb(0, eps_pkg::ADDR_SHDN, 0);
        `CHK(rdat[7], 1'b1)
        cmp1_req <= 0; cmp_sync <= 0;
        final_report();
    end
endmodule : tb_top
